/* File: dv/eow_framer_model.sv */
// stand-in for the framer feeding word pulses, serial bits and indicator requests
`timescale 1ns/1ps
module eow_framer_model (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic go,
    output logic      wordDone,
    output logic      dataIn,
    output logic      ledIn
);
    ////////////////////////////////////////////////////////////////
    // serial and indicator lines never hold still, so stale values cannot pass
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wordDone <= 1'b0;
            dataIn   <= 1'b0;
            ledIn    <= 1'b0;
        end
        else
        begin
            wordDone <= go;
            dataIn   <= ~dataIn;
            ledIn    <= dataIn;
        end
    end
endmodule : eow_framer_model

/* File: dv/eow_options_chk.sv */
// port assertions for the encoder options block
`timescale 1ns/1ps
module eow_options_chk (
    input wire logic                  sys_clk,
    input wire logic                  rst,
    input wire logic [3:0]            buttonPin,
    input wire logic                  dataIn,
    input wire logic                  ledIn,
    input wire logic                  modOut,
    input wire logic                  indicatorOn,
    input wire logic                  txAllowed,
    input wire eow_pkg::eow_tx_ctrl_t txCtrl,
    input wire logic [11:0]           discValue,
    input wire logic [31:0]           fixedIdentity
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    a_pulse_legal: assert property (!$past(rst, 2) |->
        txCtrl.basePulseWidth inside {9'h190, 9'h0C8, 9'h064}) else $error("pulse width not a legal value");
    a_ir_counterb: assert property (txCtrl.irMode |-> txCtrl.useCounterB)
        else $error("ir mode without second counter");
    a_delay_nibble: assert property ($stable(fixedIdentity) |->
        discValue[3:0] == (fixedIdentity[3:0] ^ {4{txCtrl.delayedTx}})) else $error("delay nibble wrong");
    a_tmo_quiet: assert property (!txAllowed && $past(!txAllowed) |-> !modOut && !indicatorOn)
        else $error("output active in time-out");
    a_tmo_exit: assert property ($rose(txAllowed) |-> $past(buttonPin, 4) == 4'h0)
        else $error("time-out left with a button held");
    a_led_follow: assert property (txAllowed && $past(txAllowed) |-> indicatorOn == $past(ledIn))
        else $error("indicator does not follow request");
    a_mod_follow: assert property (txAllowed && $past(txAllowed) && !txCtrl.irMode &&
        $stable(txCtrl.irMode) |-> modOut == $past(dataIn)) else $error("modulation does not follow data");
    a_ir_gate: assert property (txCtrl.irMode && txAllowed |-> !modOut || $past(dataIn))
        else $error("carrier without data");
    cover property (txCtrl.irMode);
    cover property (txCtrl.delayedTx);
    cover property (!txAllowed);
endmodule : eow_options_chk

/* File: dv/eow_tb.sv */
// self-checking bench for the encoder options block
`timescale 1ns/1ps
module tb;
    logic                  sys_clk, hreadyout, hresp, wordDone, dataIn, ledIn, modOut, indicatorOn, txAllowed;
    logic                  rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
    logic [1:0]            htrans = 2'h0;
    logic [31:0]           haddr = 32'h0, hwdata = 32'h0, hrdata, fixedIdentity, rdv;
    logic [3:0]            buttonPin = 4'h0;
    logic [11:0]           discValue;
    logic [15:0]           syncValue;
    logic [47:0]           seedData;
    eow_pkg::eow_tx_ctrl_t txCtrl;
    logic [8:0]            te [4] = '{9'h190, 9'h0C8, 9'h0C8, 9'h064};
    logic [3:0]            code [3] = '{4'h1, 4'h8, 4'hC};
    int                    failures = 0, checks_done = 0;
    eow_encoder_options #(.CLK_HZ(800000)) dut_u (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .buttonPin(buttonPin), .wordDone(wordDone),
        .dataIn(dataIn), .ledIn(ledIn), .modOut(modOut), .indicatorOn(indicatorOn), .txAllowed(txAllowed),
        .txCtrl(txCtrl), .discValue(discValue), .fixedIdentity(fixedIdentity), .syncValue(syncValue),
        .seedData(seedData));
    eow_framer_model frm_u (.sys_clk(sys_clk), .rst(rst), .go(go), .wordDone(wordDone), .dataIn(dataIn),
        .ledIn(ledIn));
    ////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [47:0] e, input logic [47:0] g);
        checks_done++;
        if (g !== e)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask : bus
    task rd(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk("hrdata", e, rdv);
        chk("hresp", 48'h0, hresp);
    endtask : rd
    // buttons pass a two-flop synchroniser, so allow settling edges
    task press(input logic [3:0] c);
        buttonPin <= c;
        repeat (5) @(posedge sys_clk);
    endtask : press
    task words(input int n);
        repeat (n)
        begin
            go <= 1'b1;
            @(posedge sys_clk);
            go <= 1'b0;
            @(posedge sys_clk);
        end
    endtask : words
    task end_of_test;
        if (failures == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        end_of_test();
    end
    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(32'h0, 32'h0);
        bus(1'b1, 32'h4, 32'h0000ABCD);
        bus(1'b1, 32'h8, 32'h00009357);
        bus(1'b1, 32'h0, 32'h0000A5F6);
        rd(32'h0, 32'h0000A5F6);
        rd(32'h4, 32'h0000ABCD);
        rd(32'h8, 32'h00009357);
        rd(32'h20, 32'h0);
        for (int s = 0; s < 4; s++)
        begin
            bus(1'b1, 32'h0, {17'h0, s[1], 1'b0, s[0], 9'h0, s[1:0], s[0]});
            press(4'h1);
            chk("pulse", te[s], txCtrl.basePulseWidth);
            chk("ident", s[0] ? 32'h9357ABCD : 32'h1357ABCD, fixedIdentity);
            chk("guard", s[0], txCtrl.longGuardEnable);
            chk("biphase", s[1], txCtrl.biphaseCodeSelect);
            press(4'h0);
        end
        bus(1'b1, 32'h0, 32'h00000680);
        for (int i = 0; i < 3; i++)
        begin
            press(code[i]);
            chk("useB", i > 0, txCtrl.useCounterB);
            chk("irMode", i == 2, txCtrl.irMode);
            chk("user", i > 0 ? 4'h5 : 4'h9, discValue[11:8]);
            press(4'h0);
        end
        bus(1'b1, 32'h0, 32'h00008000);
        bus(1'b1, 32'hC, 32'h0000FFFF);
        press(4'hC);
        chk("useB", 1'b0, txCtrl.useCounterB);
        chk("sync", 16'h0000, syncValue);
        rd(32'h0, 32'h0);
        press(4'h0);
        bus(1'b1, 32'h0, 32'h00008000);
        rd(32'h0, 32'h0);
        bus(1'b1, 32'h14, 32'h00001111);
        bus(1'b1, 32'h18, 32'h00002222);
        bus(1'b1, 32'h10, 32'h00003333);
        bus(1'b1, 32'h0, 32'h00000010);
        press(4'h9);
        chk("seedData", 48'h333322221111, seedData);
        press(4'h0);
        press(4'h5);
        chk("seedSend", 1'b0, txCtrl.seedSend);
        press(4'h0);
        bus(1'b1, 32'h0, 32'h0);
        press(4'h9);
        chk("seedSend", 1'b0, txCtrl.seedSend);
        press(4'h0);
        bus(1'b1, 32'hC, 32'h00000048);
        bus(1'b1, 32'h0, 32'h00002010);
        repeat (15)
        begin
            press(4'h1);
            press(4'h0);
        end
        press(4'h9);
        chk("seedSend", 1'b1, txCtrl.seedSend);
        press(4'h0);
        press(4'h1);
        press(4'h0);
        press(4'h9);
        chk("seedSend", 1'b0, txCtrl.seedSend);
        chk("seedData", 48'h0, seedData);
        press(4'h0);
        rd(32'h14, 32'h0);
        bus(1'b1, 32'h0, 32'h00000060);
        press(4'h1);
        words(27);
        chk("delayed", 1'b0, txCtrl.delayedTx);
        words(1);
        repeat (3) @(posedge sys_clk);
        chk("delayed", 1'b1, txCtrl.delayedTx);
        chk("disc", 4'h2, discValue[3:0]);
        words(227);
        chk("txAllowed", 1'b1, txAllowed);
        words(1);
        repeat (3) @(posedge sys_clk);
        chk("txAllowed", 1'b0, txAllowed);
        chk("quiet", 2'h0, {modOut, indicatorOn});
        press(4'h2);
        chk("txAllowed", 1'b0, txAllowed);
        press(4'h0);
        chk("txAllowed", 1'b1, txAllowed);
        end_of_test();
    end
endmodule : tb
bind eow_encoder_options eow_options_chk chk_u (.sys_clk(sys_clk), .rst(rst), .buttonPin(buttonPin),
    .dataIn(dataIn), .ledIn(ledIn), .modOut(modOut), .indicatorOn(indicatorOn), .txAllowed(txAllowed),
    .txCtrl(txCtrl), .discValue(discValue), .fixedIdentity(fixedIdentity));

/* File: rtl/eow_encoder_options.sv */
// option word, identity words and the option-driven steering of the hopping encoder
//
// Operation
// - one 16-bit option word holds every encoder option field.
// - long guard bit set lengthens the guard between code words.
// - pulse select 00 gives 400, 01 and 10 give 200, 11 gives 100.
// - seed clear disables seed; counter B shares storage with seed word two.
// - seed set and seed code sends seed words plus upper identity bits.
// - seed only on code 1001 immediately or 0011 after delay.
// - delay mode marks delayed words by inverting discrimination low nibble.
// - delay begins after 28 words for selects 00/10, 56 for 01/11.
// - time-out stops sending, drives modulation low, indicator off.
// - time-out state left only after all buttons return low.
// - time-out limit is 256 words for 00/10, 512 for 01/11.
// - time-out clear means sending continues while a button is held.
// - dual counter clear uses counter A for all codes, advancing it except on a code 1001 seed send.
// - dual counter set: codes 1-7 use counter A, 8-15 counter B.
// - dual counter set and codes C-F give IR mode, 40 kHz carrier.
// - user bits are inserted into the discrimination value.
// - extended identity sends 32 bits, else top nibble is button code.
// - temporary learn locks seed after hops set by counter initial value.
// - identity number is two 16-bit words, low then high.
// - once locked, seed values cannot be sent, and read as zero except seed word two while dual counter is set.
// - biphase select one chooses Manchester, zero chooses pulse width coding.
// - overflow flag cleared on first counter wrap, never set again.
`timescale 1ns/1ps
module eow_encoder_options #(
    parameter int CLK_HZ = 20_000_000
) (
    input  wire logic          sys_clk,
    input  wire logic          rst,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic [31:0]        hrdata,
    output logic               hresp,
    input  wire logic [3:0]    buttonPin,
    input  wire logic          wordDone,
    input  wire logic          dataIn,
    input  wire logic          ledIn,
    output logic               modOut,
    output logic               indicatorOn,
    output logic               txAllowed,
    output eow_pkg::eow_tx_ctrl_t txCtrl,
    output logic [11:0]        discValue,
    output logic [31:0]        fixedIdentity,
    output logic [15:0]        syncValue,
    output logic [47:0]        seedData
);
    localparam int CARRIER_HALF = CLK_HZ / (2 * eow_pkg::CARRIER_HZ);
    localparam int CW           = $clog2(CARRIER_HALF + 1);
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_ACTIVE  = 2'b01,
        ST_TIMEOUT = 2'b10
    } eow_state_t;
    function automatic logic mapped(input logic [31:0] a);
        mapped = (a[31:5] == 27'h0) && (a[1:0] == 2'b00);
    endfunction : mapped
    function automatic logic [7:0] hopsFor(input logic [15:0] v);
        case (v)
            eow_pkg::INIT_64: hopsFor = eow_pkg::HOPS_64;
            eow_pkg::INIT_32: hopsFor = eow_pkg::HOPS_32;
            eow_pkg::INIT_16: hopsFor = eow_pkg::HOPS_16;
            default:          hopsFor = eow_pkg::HOPS_128;
        endcase
    endfunction : hopsFor
    ////////////////////////////////////////////////////////////////////////
    // registers and session state
    eow_pkg::eow_option_t opt;
    logic [15:0]          idLow;
    logic [15:0]          idHigh;
    logic [15:0]          countA;
    logic [15:0]          countB;
    logic [15:0]          seed0;
    logic [15:0]          seed1;
    logic                 ovrSpent;
    logic                 locked;
    logic [7:0]           hopCount;
    logic [7:0]           lockLimit;
    logic [9:0]           wordCount;
    logic [3:0]           lastCode;
    logic [3:0]           btnMeta;
    logic [3:0]           btnSync;
    logic [CW-1:0]        carrierCnt;
    logic                 carrier;
    eow_state_t           state;
    eow_state_t           next_state;
    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: writes land in the data phase, reads take one wait
    logic        wrPend;
    logic        rdPend;
    logic        rdWait;
    logic [4:0]  wrAddr;
    logic [4:0]  rdAddr;
    logic        wrMapped;
    logic        rdMapped;
    wire         addrPhase = hsel && hready && htrans[1];
    wire         doWrite   = wrPend && wrMapped;
    wire         wrOption  = doWrite && (wrAddr == eow_pkg::ADDR_OPTION);
    wire         wrIdLow   = doWrite && (wrAddr == eow_pkg::ADDR_ID_LOW);
    wire         wrIdHigh  = doWrite && (wrAddr == eow_pkg::ADDR_ID_HIGH);
    wire         wrCountA  = doWrite && (wrAddr == eow_pkg::ADDR_COUNT_A);
    wire         wrCountB  = doWrite && (wrAddr == eow_pkg::ADDR_COUNT_B);
    wire         wrSeed0   = doWrite && (wrAddr == eow_pkg::ADDR_SEED0);
    wire         wrSeed1   = doWrite && (wrAddr == eow_pkg::ADDR_SEED1);
    wire [15:0]  wrWord    = hwdata[15:0];
    assign hreadyout = !(rdPend && rdWait);
    assign hresp     = 1'b0;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wrPend   <= 1'b0;
            rdPend   <= 1'b0;
            rdWait   <= 1'b0;
            wrAddr   <= 5'h00;
            rdAddr   <= 5'h00;
            wrMapped <= 1'b0;
            rdMapped <= 1'b0;
        end
        else if (hreadyout)
        begin
            wrPend   <= addrPhase && hwrite;
            rdPend   <= addrPhase && !hwrite;
            rdWait   <= addrPhase && !hwrite;
            wrAddr   <= haddr[4:0];
            rdAddr   <= haddr[4:0];
            wrMapped <= mapped(haddr);
            rdMapped <= mapped(haddr);
        end
        else
            rdWait <= 1'b0;
    end

    // seed words read as zero once learning is locked, word two only while dual counter is clear
    wire [15:0] seedView0 = locked ? 16'h0000 : seed0;
    wire [15:0] seedView1 = locked ? 16'h0000 : seed1;
    wire [15:0] seedView2 = (locked && !opt.dualCounterSelect) ? 16'h0000 : countB;
    wire [15:0] statusWord;
    logic [15:0] readWord;
    always_comb
    begin
        readWord = 16'h0000;
        if (rdMapped)
        begin
            case (rdAddr)
                eow_pkg::ADDR_OPTION:  readWord = opt;
                eow_pkg::ADDR_ID_LOW:  readWord = idLow;
                eow_pkg::ADDR_ID_HIGH: readWord = idHigh;
                eow_pkg::ADDR_COUNT_A: readWord = countA;
                eow_pkg::ADDR_COUNT_B: readWord = seedView2;
                eow_pkg::ADDR_SEED0:   readWord = seedView0;
                eow_pkg::ADDR_SEED1:   readWord = seedView1;
                eow_pkg::ADDR_STATUS:  readWord = statusWord;
                default:               readWord = 16'h0000;
            endcase
        end
    end
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            hrdata <= 32'h0000_0000;
        else if (rdPend && rdWait)
            hrdata <= {16'h0000, readWord};
    end
    ////////////////////////////////////////////////////////////////////////
    // button code and option decoding
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            btnMeta <= 4'h0;
            btnSync <= 4'h0;
        end
        else
        begin
            btnMeta <= buttonPin;
            btnSync <= btnMeta;
        end
    end
    wire [3:0] code    = btnSync;
    wire       anyBtn  = (code != 4'h0);
    wire       selLow  = opt.pulseSelect[0];
    wire [8:0] tePick  = (opt.pulseSelect == 2'b00) ? eow_pkg::TE_SLOW :
                         (opt.pulseSelect == 2'b11) ? eow_pkg::TE_FAST :
                                                      eow_pkg::TE_MID;
    wire [9:0] delayAt = selLow ? eow_pkg::DELAY_WORDS_HI : eow_pkg::DELAY_WORDS_LO;
    wire [9:0] tmoAt   = selLow ? eow_pkg::TMO_WORDS_HI : eow_pkg::TMO_WORDS_LO;
    wire useB   = opt.dualCounterSelect && (code >= eow_pkg::FIRST_B_CODE);
    wire irMode = opt.dualCounterSelect && (code >= eow_pkg::FIRST_IR_CODE);
    wire delayActive = opt.delayModeEnable && (wordCount >= delayAt);
    wire seedCode    = (code == eow_pkg::SEED_NOW_CODE) ||
                       ((code == eow_pkg::SEED_LATE_CODE) && delayActive);
    wire seedSend    = opt.seedEnable && !locked && seedCode;
    wire seedAtStart = opt.seedEnable && !locked && (code == eow_pkg::SEED_NOW_CODE);
    wire tmoHit      = opt.timeOutEnable && (wordCount >= tmoAt);
    ////////////////////////////////////////////////////////////////////////
    // session sequencing: a new or changed code restarts the word count, except in time-out
    wire newCode      = anyBtn && (code != lastCode);
    wire sessionStart = newCode && (state != ST_TIMEOUT);
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (anyBtn)
                    next_state = ST_ACTIVE;
            ST_ACTIVE:
                if (!anyBtn)
                    next_state = ST_IDLE;
                else if (tmoHit && !newCode)
                    next_state = ST_TIMEOUT;
            ST_TIMEOUT:
                if (!anyBtn)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state     <= ST_IDLE;
            lastCode  <= 4'h0;
            wordCount <= 10'h000;
        end
        else
        begin
            state    <= next_state;
            lastCode <= code;
            if (sessionStart || !anyBtn)
                wordCount <= 10'h000;
            else if (wordDone && (state == ST_ACTIVE) && (wordCount != 10'h3FF))
                wordCount <= wordCount + 10'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // synchronisation counters, overflow flag and temporary learn lock
    // a seed word carries no counter, so it does not advance one
    wire hopStart = sessionStart && !seedAtStart;
    wire incA     = hopStart && !useB;
    wire incB     = hopStart && useB;
    wire wrapEvt  = (incA && (countA == 16'hFFFF)) ||
                    (incB && (countB == 16'hFFFF));
    wire lockHit  = opt.temporaryLearnEnable && hopStart &&
                    ((hopCount + 8'd1) >= lockLimit);
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            countA <= eow_pkg::RESET_WORD;
            countB <= eow_pkg::RESET_WORD;
        end
        else
        begin
            if (wrCountA)
                countA <= wrWord;
            else if (incA)
                countA <= countA + 16'h0001;
            if (wrCountB)
                countB <= wrWord;
            else if (incB)
                countB <= countB + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            hopCount  <= 8'h00;
            lockLimit <= eow_pkg::HOPS_128;
            locked    <= 1'b0;
        end
        else
        begin
            if (wrCountA || wrCountB)
            begin
                hopCount  <= 8'h00;
                lockLimit <= hopsFor(wrWord);
            end
            else if (hopStart && (hopCount != 8'hFF))
                hopCount <= hopCount + 8'h01;
            if (lockHit)
                locked <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // option, identity and seed storage
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            opt      <= eow_pkg::RESET_WORD;
            ovrSpent <= 1'b0;
            idLow    <= eow_pkg::RESET_WORD;
            idHigh   <= eow_pkg::RESET_WORD;
            seed0    <= eow_pkg::RESET_WORD;
            seed1    <= eow_pkg::RESET_WORD;
        end
        else
        begin
            if (wrOption)
            begin
                opt              <= wrWord;
                opt.overflowFlag <= wrWord[15] && !ovrSpent && !wrapEvt;
            end
            else if (wrapEvt)
                opt.overflowFlag <= 1'b0;
            if (wrapEvt)
                ovrSpent <= 1'b1;
            if (wrIdLow)
                idLow <= wrWord;
            if (wrIdHigh)
                idHigh <= wrWord;
            if (wrSeed0 && !locked)
                seed0 <= wrWord;
            if (wrSeed1 && !locked)
                seed1 <= wrWord;
        end
    end

    assign statusWord = {1'b0, locked, (state == ST_TIMEOUT), delayActive,
                         seedSend, irMode, useB, opt.biphaseCodeSelect, wordCount[9:2]};
    ////////////////////////////////////////////////////////////////////////
    // IR carrier derived from the system clock
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            carrierCnt <= '0;
            carrier    <= 1'b0;
        end
        else if (carrierCnt == CW'(CARRIER_HALF - 1))
        begin
            carrierCnt <= '0;
            carrier    <= !carrier;
        end
        else
            carrierCnt <= carrierCnt + CW'(1);
    end

    ////////////////////////////////////////////////////////////////////////
    // values handed to the framer, all registered
    wire       inTimeout = (state == ST_TIMEOUT);
    wire [1:0] userPair  = useB ? {opt.userBitB1, opt.userBitB0}
                                : {opt.userBitA1, opt.userBitA0};
    wire       delayMark = delayActive && !seedSend;
    wire [7:0] discLow   = idLow[7:0] ^ {4'h0, {4{delayMark}}};
    wire [11:0] next_disc = {userPair, opt.overflowFlag, opt.dualCounterSelect, discLow};
    wire [31:0] next_fixed = opt.extendedIdentityEnable ? {idHigh, idLow}
                                                        : {code, idHigh[11:0], idLow};
    wire [47:0] next_seed  = seedSend ? {countB, seed1, seed0} : 48'h0;
    wire        next_mod   = !inTimeout && (irMode ? (dataIn && carrier) : dataIn);
    eow_pkg::eow_tx_ctrl_t next_txCtrl;
    assign next_txCtrl.basePulseWidth    = tePick;
    assign next_txCtrl.longGuardEnable   = opt.longGuardEnable;
    assign next_txCtrl.biphaseCodeSelect = opt.biphaseCodeSelect;
    assign next_txCtrl.irMode            = irMode;
    assign next_txCtrl.useCounterB       = useB;
    assign next_txCtrl.seedSend          = seedSend;
    assign next_txCtrl.delayedTx         = delayMark;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            txCtrl        <= '0;
            discValue     <= 12'h000;
            fixedIdentity <= 32'h0000_0000;
            syncValue     <= 16'h0000;
            seedData      <= 48'h0;
            modOut        <= 1'b0;
            indicatorOn   <= 1'b0;
            txAllowed     <= 1'b1;
        end
        else
        begin
            txCtrl        <= next_txCtrl;
            discValue     <= next_disc;
            fixedIdentity <= next_fixed;
            syncValue     <= useB ? countB : countA;
            seedData      <= next_seed;
            modOut        <= next_mod;
            indicatorOn   <= ledIn && !inTimeout;
            txAllowed     <= !inTimeout;
        end
    end

endmodule : eow_encoder_options

/* File: rtl/eow_pkg.sv */
// option word layout, register map, limits and carrier of the encoder options block
package eow_pkg;

    typedef struct packed {
        logic       overflowFlag;
        logic       biphaseCodeSelect;
        logic       temporaryLearnEnable;
        logic       extendedIdentityEnable;
        logic       userBitB1;
        logic       userBitB0;
        logic       userBitA1;
        logic       userBitA0;
        logic       dualCounterSelect;
        logic       timeOutEnable;
        logic       delayModeEnable;
        logic       seedEnable;
        logic       notUsed;
        logic [1:0] pulseSelect;
        logic       longGuardEnable;
    } eow_option_t;

    typedef struct packed {
        logic [8:0] basePulseWidth;
        logic       longGuardEnable;
        logic       biphaseCodeSelect;
        logic       irMode;
        logic       useCounterB;
        logic       seedSend;
        logic       delayedTx;
    } eow_tx_ctrl_t;

    localparam logic [4:0]  ADDR_OPTION    = 5'h00;
    localparam logic [4:0]  ADDR_ID_LOW    = 5'h04;
    localparam logic [4:0]  ADDR_ID_HIGH   = 5'h08;
    localparam logic [4:0]  ADDR_COUNT_A   = 5'h0C;
    localparam logic [4:0]  ADDR_COUNT_B   = 5'h10;
    localparam logic [4:0]  ADDR_SEED0     = 5'h14;
    localparam logic [4:0]  ADDR_SEED1     = 5'h18;
    localparam logic [4:0]  ADDR_STATUS    = 5'h1C;
    localparam logic [15:0] RESET_WORD     = 16'h0000;
    localparam logic [8:0]  TE_SLOW        = 9'd400;
    localparam logic [8:0]  TE_MID         = 9'd200;
    localparam logic [8:0]  TE_FAST        = 9'd100;
    localparam logic [9:0]  DELAY_WORDS_LO = 10'd28;
    localparam logic [9:0]  DELAY_WORDS_HI = 10'd56;
    localparam logic [9:0]  TMO_WORDS_LO   = 10'd256;
    localparam logic [9:0]  TMO_WORDS_HI   = 10'd512;
    localparam logic [3:0]  SEED_NOW_CODE  = 4'h9;
    localparam logic [3:0]  SEED_LATE_CODE = 4'h3;
    localparam logic [3:0]  FIRST_B_CODE   = 4'h8;
    localparam logic [3:0]  FIRST_IR_CODE  = 4'hC;
    localparam logic [15:0] INIT_128       = 16'h0000;
    localparam logic [15:0] INIT_64        = 16'h0060;
    localparam logic [15:0] INIT_32        = 16'h0050;
    localparam logic [15:0] INIT_16        = 16'h0048;
    localparam logic [7:0]  HOPS_128       = 8'd128;
    localparam logic [7:0]  HOPS_64        = 8'd64;
    localparam logic [7:0]  HOPS_32        = 8'd32;
    localparam logic [7:0]  HOPS_16        = 8'd16;
    localparam int          CARRIER_HZ     = 40000;

endpackage : eow_pkg
